// ==== dv/sbtc_timer_properties.sv ====
// Purpose: Port-level properties of the timer/counter.
// Assumes: The stop, rate and trigger checks only judge the count once both bytes were written together.
// Notes:   Bound to every sbtc_timer instance.
module sbtc_timer_checker
  import sbtc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] counter_control_reg,
  input wire logic       count_high_wr,
  input wire logic       count_low_wr,
  input wire logic [7:0] count_wdata,
  input wire logic [7:0] count_high_byte,
  input wire logic [7:0] count_low_byte,
  input wire logic       overflow_flag_clr,
  input wire logic       overflow_enable,
  input wire logic       overflow_flag,
  input wire logic       overflow_irq,
  input wire logic       sleep,
  input wire logic [3:0] compare_mode_field,
  input wire logic [7:0] compare_value_high,
  input wire logic [7:0] compare_value_low,
  input wire logic       adc_enable,
  input wire logic       adc_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // The bytes power up unknown and no reset clears them, so stay quiet until a full write.
  logic        armed_q = 1'b0;
  wire  [15:0] cnt     = {count_high_byte, count_low_byte};
  wire         no_wr   = !count_high_wr && !count_low_wr;
  wire         special = compare_mode_field == CMP_MODE_SPECIAL;
  wire         match   = armed_q && special && cnt == {compare_value_high, compare_value_low};
  wire         tmr_run = armed_q && no_wr && !special && !sleep && counter_control_reg[1:0] == 2'h1
                         && counter_control_reg[5:4] == PS_DIV1;
  always @(posedge ref_clk)
    if (count_high_wr && count_low_wr) armed_q <= 1'b1;

  AST_CTRL_WR: assert property (ctrl_wr |=> counter_control_reg == ($past(ctrl_wdata) & CTRL_WRITE_MASK))
    else $error("control write not taken");
  AST_HIGH_WR: assert property (count_high_wr |=> count_high_byte == $past(count_wdata))
    else $error("high byte write lost");
  AST_LOW_WR: assert property (count_low_wr |=> count_low_byte == $past(count_wdata))
    else $error("low byte write lost");
  AST_STOPPED: assert property (armed_q && no_wr && !special && counter_control_reg[1:0] == 2'h0
    && !$past(counter_control_reg[0]) |=> $stable(cnt)) else $error("stopped counter moved");
  AST_TIMER_RATE: assert property (tmr_run [*8] |-> cnt == 16'($past(cnt, 4) + 16'h1))
    else $error("timer rate not one per four clocks");
  AST_OVF: assert property ((cnt == COUNT_MAX && no_wr && !special) ##1
    (cnt == COUNT_ZERO && !overflow_flag_clr) |=> overflow_flag) else $error("wrap without flag");
  AST_IRQ: assert property (overflow_flag && overflow_enable |=> overflow_irq)
    else $error("enabled flag gave no wake");
  AST_SPECIAL: assert property (match && no_wr && counter_control_reg[0]
    && !(counter_control_reg[1] && counter_control_reg[2]) |=> cnt == COUNT_ZERO) else $error("no trigger clear");
  AST_ADC: assert property ($rose(match) && adc_enable |=> adc_start)
    else $error("no conversion start");
endmodule

bind sbtc_timer sbtc_timer_checker u_sbtc_timer_checker (.*);

// ==== dv/sbtc_xtal_model.sv ====
// Purpose: Behavioural low-power crystal or external count clock.
// Assumes: The bench raises run only after the start-up wait.
// Notes:   The pin rests low between bursts, as a stopped source would.
module sbtc_xtal_model #(
  parameter int HALF_NS = 15259
) (
  input  wire logic run,
  output logic      clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial clk_pin = 1'b0;
  always begin
    #(HALF_NS);
    clk_pin = run ? !clk_pin : 1'b0;
  end
endmodule

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the timer/counter.
// Assumes: Counts are judged in ranges where the free divider phase is unknown.
// Notes:   The shared clock pin level is resolved here from the output enable.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sbtc_pkg::*;
  logic       ref_clk = 1'b0, nrst = 1'b0, ctrl_wr = 1'b0, count_high_wr = 1'b0, count_low_wr = 1'b0;
  logic       overflow_flag_clr = 1'b0, overflow_enable = 1'b0, sleep = 1'b0, adc_enable = 1'b0, xrun = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00, count_wdata = 8'h00, compare_value_high = 8'h00, compare_value_low = 8'h00;
  logic [3:0] compare_mode_field = 4'h0;
  logic [7:0] counter_control_reg, count_high_byte, count_low_byte;
  logic       overflow_flag, overflow_irq, adc_start, lp_osc_out_pin_o, lp_osc_out_pin_oe_n, lp_osc_enable;
  logic       lp_osc_in_pin;
  wire        lp_osc_out_pin_i = lp_osc_out_pin_oe_n ? lp_osc_in_pin : lp_osc_out_pin_o;
  wire [15:0] cnt = {count_high_byte, count_low_byte};
  int         mismatches = 0, compares = 0;

  always #50 ref_clk = !ref_clk;
  sbtc_timer u_sbtc_timer (.*);
  sbtc_xtal_model u_sbtc_xtal_model (.run(xrun), .clk_pin(lp_osc_in_pin));

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    compares++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr_ctrl(input logic [7:0] d);
    @(posedge ref_clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= d;
    @(posedge ref_clk);
    ctrl_wr <= 1'b0;
    #1;
  endtask
  task automatic wr_cnt(input logic hi, input logic lo, input logic [7:0] d);
    @(posedge ref_clk);
    count_high_wr <= hi;
    count_low_wr <= lo;
    count_wdata <= d;
    @(posedge ref_clk);
    count_high_wr <= 1'b0;
    count_low_wr <= 1'b0;
    #1;
  endtask
  // Stop first: a write racing an increment has no defined result.
  task automatic load(input logic [15:0] v);
    wr_ctrl(8'h00);
    wr_cnt(1'b0, 1'b1, v[7:0]);
    wr_cnt(1'b1, 1'b0, v[15:8]);
  endtask
  // Two byte reads can straddle a low-byte carry, so the high byte is read again.
  task automatic rd_pair(output logic [15:0] v);
    logic [7:0] hi;
    v = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      hi = count_high_byte;
      cyc(1);
      v = {hi, count_low_byte};
      cyc(1);
      if (count_high_byte === hi) return;
    end
    mismatches++;
    $display("MISMATCH t=%0t pair read never settled", $time);
  endtask
  task automatic burst;
    @(posedge ref_clk);
    xrun <= 1'b1;
    cyc(1220);
    @(posedge ref_clk);
    xrun <= 1'b0;
    cyc(400);
  endtask
  task automatic test_done;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic t_reset;
    chk_eq(16'(counter_control_reg), 16'(CTRL_RESET));
    wr_cnt(1'b1, 1'b1, 8'h12);
    wr_ctrl(8'hc8);
    cyc(1);
    chk_eq(16'(counter_control_reg), 16'(8'hc8 & CTRL_WRITE_MASK));
    chk_eq(16'({lp_osc_enable, lp_osc_out_pin_oe_n}), 16'h0002);
    @(posedge ref_clk);
    nrst <= 1'b0;
    cyc(2);
    chk_eq(cnt, 16'h1212);
    chk_eq(16'(counter_control_reg), 16'(CTRL_RESET));
    @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(1);
  endtask
  task automatic t_timer;
    for (int ps = 0; ps < 4; ps++) begin
      load(16'h0000);
      wr_ctrl(8'h05 | 8'(ps << 4));
      cyc(64 << ps);
      chk_rng(cnt, 16'd14, 16'd16);
    end
    // Clearing faster than one 1:8 period must hold the count still.
    for (int i = 0; i < 6; i++) begin
      wr_cnt(1'b0, 1'b1, 8'h40);
      cyc(22);
      chk_eq(cnt, 16'h0040);
    end
  endtask
  task automatic t_overflow;
    load(16'hfffe);
    @(posedge ref_clk);
    overflow_enable <= 1'b1;
    wr_ctrl(8'h01);
    cyc(16);
    chk_rng(cnt, 16'h0000, 16'h0003);
    chk_eq(16'({overflow_flag, overflow_irq}), 16'h0003);
    @(posedge ref_clk);
    overflow_flag_clr <= 1'b1;
    overflow_enable <= 1'b0;
    @(posedge ref_clk);
    overflow_flag_clr <= 1'b0;
    cyc(2);
    chk_eq(16'({overflow_flag, overflow_irq}), 16'h0000);
  endtask
  task automatic t_special;
    int n;
    logic [15:0] top;
    n = 0;
    top = 16'h0000;
    load(16'h0000);
    @(posedge ref_clk);
    compare_value_low <= 8'h09;
    compare_mode_field <= CMP_MODE_SPECIAL;
    adc_enable <= 1'b1;
    wr_ctrl(8'h01);
    repeat (200) begin
      cyc(1);
      n += (adc_start === 1'b1);
      top = (cnt > top) ? cnt : top;
    end
    chk_eq(top, 16'h0009);
    chk_rng(16'(n), 16'd4, 16'd6);
    @(posedge ref_clk);
    compare_mode_field <= 4'h0;
    load(16'h0009);
    @(posedge ref_clk);
    compare_mode_field <= CMP_MODE_SPECIAL;
    count_high_wr <= 1'b1;
    count_low_wr <= 1'b1;
    count_wdata <= 8'h55;
    @(posedge ref_clk);
    count_high_wr <= 1'b0;
    count_low_wr <= 1'b0;
    compare_mode_field <= 4'h0;
    cyc(1);
    chk_eq(cnt, 16'h5555);
  endtask
  task automatic t_external;
    logic [15:0] v;
    load(16'h0000);
    wr_ctrl(8'h0f);
    cyc(40);
    @(posedge ref_clk);
    sleep <= 1'b1;
    burst();
    chk_rng(cnt, 16'd2, 16'd5);
    chk_eq(16'({lp_osc_out_pin_o, lp_osc_out_pin_oe_n}), 16'h0002);
    load(16'h0000);
    wr_ctrl(8'h0b);
    burst();
    chk_eq(cnt, 16'h0000);
    @(posedge ref_clk);
    sleep <= 1'b0;
    burst();
    chk_rng(cnt, 16'd2, 16'd5);
    rd_pair(v);
    chk_rng(v, 16'd2, 16'd5);
    // With the oscillator off the count arrives on the amplifier pin, and an
    // asynchronous counter must run straight past a period match.
    load(16'h0000);
    @(posedge ref_clk);
    compare_value_low <= 8'h01;
    compare_mode_field <= CMP_MODE_SPECIAL;
    wr_ctrl(8'h07);
    burst();
    chk_rng(cnt, 16'd2, 16'd5);
    chk_eq(16'({lp_osc_out_pin_o, lp_osc_out_pin_oe_n}), 16'h0001);
    @(posedge ref_clk);
    compare_mode_field <= 4'h0;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(1);
    t_reset();
    t_timer();
    t_overflow();
    t_special();
    t_external();
    test_done();
  end
endmodule

// ==== logic/sbtc_pkg.sv ====
// Purpose: Constants shared by the sixteen-bit asynchronous timer/counter.
// Assumes: ref_clk is the oscillator clock (Fosc), 10 MHz.
// Notes:   Control register layout, reset value, prescale codes and trigger mode.

package sbtc_pkg;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ON_BIT      = 0;
  localparam int unsigned CTRL_CS_BIT      = 1;
  localparam int unsigned CTRL_NOSYNC_BIT  = 2;
  localparam int unsigned CTRL_OSCEN_BIT   = 3;
  localparam int unsigned CTRL_PS_LSB      = 4;
  localparam int unsigned CTRL_PS_MSB      = 5;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  CTRL_WRITE_MASK  = 8'h3f;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV2 = 2'h1;
  localparam logic [1:0] PS_DIV4 = 2'h2;
  localparam logic [1:0] PS_DIV8 = 2'h3;
  localparam logic [2:0] PSC_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Internal clock and oscillator
  // ----------------------------------------------------------------
  localparam int unsigned FOSC_DIVIDE     = 4;
  localparam logic [1:0]  INT_DIV_LAST    = 2'(FOSC_DIVIDE - 1);
  localparam logic [1:0]  INT_DIV_RESET   = 2'h0;
  localparam real         LP_OSC_MAX_KHZ  = 32.768;
  localparam int unsigned SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // Compare unit
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMP_MODE_SPECIAL = 4'hb;
  localparam logic [15:0] COUNT_MAX        = 16'hffff;
  localparam logic [15:0] COUNT_ZERO       = 16'h0000;

endpackage

// ==== logic/sbtc_timer.sv ====
// Purpose: Sixteen-bit timer/counter with prescaler, low-power oscillator
//          enable, compare-unit special event clear and overflow flag.
// Assumes: ref_clk is Fosc; all pins are sampled through two flip-flops.
// Notes:   The count bytes carry no reset at all; they power up unknown.

module sbtc_timer
  import sbtc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,

  // Control register access
  input  wire logic        ctrl_wr,
  input  wire logic [7:0]  ctrl_wdata,
  output logic      [7:0]  counter_control_reg,

  // Count byte access
  input  wire logic        count_high_wr,
  input  wire logic        count_low_wr,
  input  wire logic [7:0]  count_wdata,
  output logic      [7:0]  count_high_byte,
  output logic      [7:0]  count_low_byte,

  // Overflow flag and wake
  input  wire logic        overflow_flag_clr,
  input  wire logic        overflow_enable,
  output logic             overflow_flag,
  output logic             overflow_irq,

  // Processor state
  input  wire logic        sleep,

  // Compare unit
  input  wire logic [3:0]  compare_mode_field,
  input  wire logic [7:0]  compare_value_high,
  input  wire logic [7:0]  compare_value_low,
  input  wire logic        adc_enable,
  output logic             adc_start,

  // Oscillator and clock pins
  input  wire logic        lp_osc_in_pin,
  input  wire logic        lp_osc_out_pin_i,
  output logic             lp_osc_out_pin_o,
  output logic             lp_osc_out_pin_oe_n,
  output logic             lp_osc_enable
);

  import sbtc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [1:0]  pin_meta_q;
  logic [1:0]  pin_sync_q;
  logic        src_prev_q;
  logic        armed_q;
  logic [2:0]  psc_q;
  logic [2:0]  psc_d;
  logic [1:0]  int_div_q;
  logic [1:0]  tick_pipe_q;
  logic        ovf_q;
  logic        irq_q;
  logic        se_prev_q;
  logic        adc_q;
  logic        osc_out_q;
  logic        osc_oe_n_q;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire         on_w      = ctrl_q[CTRL_ON_BIT];
  wire         ext_w     = ctrl_q[CTRL_CS_BIT];
  wire         nosync_w  = ctrl_q[CTRL_NOSYNC_BIT];
  wire         oscen_w   = ctrl_q[CTRL_OSCEN_BIT];
  wire [1:0]   ps_w      = ctrl_q[CTRL_PS_MSB:CTRL_PS_LSB];
  wire         async_w   = ext_w & nosync_w;
  wire         any_wr    = count_high_wr | count_low_wr;

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  // With the oscillator on the input pin carries the crystal clock;
  // otherwise the amplifier pin is an ordinary external clock input.
  wire src_w  = oscen_w ? pin_sync_q[0] : pin_sync_q[1];
  wire rise_w = src_w & ~src_prev_q;
  wire fall_w = ~src_w & src_prev_q;

  // Fosc/4 tick; the sync bit is not consulted on this path.
  wire int_tick_w = (int_div_q == INT_DIV_LAST);

  // A counter needs one falling edge after enabling before it counts.
  wire src_edge_w = ext_w ? (rise_w & armed_q) : int_tick_w;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [2:0] psc_last_w;
  always_comb begin
    unique case (ps_w)
      PS_DIV1: psc_last_w = 3'h0;
      PS_DIV2: psc_last_w = 3'h1;
      PS_DIV4: psc_last_w = 3'h3;
      PS_DIV8: psc_last_w = 3'h7;
    endcase
  end

  wire psc_step_w = on_w & src_edge_w;
  wire psc_tick_w = psc_step_w & (psc_q == psc_last_w);

  always_comb begin
    psc_d = psc_q;
    if (psc_tick_w) begin
      psc_d = PSC_RESET;
    end else if (psc_step_w) begin
      psc_d = psc_q + 3'h1;
    end
    if (any_wr) begin
      psc_d = PSC_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Increment selection
  // ----------------------------------------------------------------
  // The synchroniser stage is halted in Sleep while the prescaler is not,
  // so a synchronised counter loses ticks during Sleep by design.
  wire inc_timer_w = ~ext_w & psc_tick_w & ~sleep;
  wire inc_sync_w  = ext_w & ~nosync_w & tick_pipe_q[1] & ~sleep;
  wire inc_async_w = async_w & psc_tick_w;
  wire inc_w       = on_w & (inc_timer_w | inc_sync_w | inc_async_w);

  // ----------------------------------------------------------------
  // Special event trigger
  // ----------------------------------------------------------------
  wire [15:0] period_w = {compare_value_high, compare_value_low};
  wire se_hit_w   = (compare_mode_field == CMP_MODE_SPECIAL) &&
                    (count_q == period_w);
  // The clear is not honoured by an asynchronous counter.
  wire se_clear_w = se_hit_w & ~async_w;
  wire wrap_w     = inc_w & (count_q == COUNT_MAX);

  always_comb begin
    count_d = count_q;
    if (se_clear_w) begin
      count_d = COUNT_ZERO;
    end else if (inc_w) begin
      count_d = count_q + 16'h0001;
    end
    // A written byte replaces whatever the increment produced.
    if (count_high_wr) begin
      count_d[15:8] = count_wdata;
    end
    if (count_low_wr) begin
      count_d[7:0] = count_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Counter bytes: no reset of any kind
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    count_q <= count_d;
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_wdata & CTRL_WRITE_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge tracking
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
      src_prev_q <= 1'b0;
      armed_q    <= 1'b0;
    end else begin
      pin_meta_q <= {lp_osc_out_pin_i, lp_osc_in_pin};
      pin_sync_q <= pin_meta_q;
      src_prev_q <= src_w;
      if (!on_w || !ext_w) begin
        armed_q <= 1'b0;
      end else if (fall_w) begin
        armed_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler, internal divider and tick synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      psc_q       <= PSC_RESET;
      int_div_q   <= INT_DIV_RESET;
      tick_pipe_q <= 2'h0;
    end else begin
      psc_q       <= psc_d;
      int_div_q   <= int_div_q + 2'h1;
      tick_pipe_q <= {tick_pipe_q[0], psc_tick_w & ext_w & ~nosync_w};
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag, trigger pulse and oscillator drive
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ovf_q      <= 1'b0;
      irq_q      <= 1'b0;
      se_prev_q  <= 1'b0;
      adc_q      <= 1'b0;
      osc_out_q  <= 1'b0;
      osc_oe_n_q <= 1'b1;
    end else begin
      // A wrap in the clearing cycle keeps the flag set.
      if (wrap_w) begin
        ovf_q <= 1'b1;
      end else if (overflow_flag_clr) begin
        ovf_q <= 1'b0;
      end
      irq_q     <= (ovf_q | wrap_w) & overflow_enable;
      se_prev_q <= se_hit_w;
      adc_q     <= se_hit_w & ~se_prev_q & adc_enable;
      // Amplifier output: inverted crystal input; it keeps running in
      // Sleep since nothing here looks at the sleep input.
      osc_out_q  <= oscen_w & ~pin_sync_q[0];
      osc_oe_n_q <= ~oscen_w;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign counter_control_reg = ctrl_q;
  assign count_high_byte     = count_q[15:8];
  assign count_low_byte      = count_q[7:0];
  assign overflow_flag       = ovf_q;
  assign overflow_irq        = irq_q;
  assign adc_start           = adc_q;
  assign lp_osc_out_pin_o    = osc_out_q;
  assign lp_osc_out_pin_oe_n = osc_oe_n_q;
  assign lp_osc_enable       = ctrl_q[CTRL_OSCEN_BIT];

endmodule
